// file: core/ref_pll_cfg.svh
// Offsets, field positions, reset values and fixed figures of the reference select and divider block
`ifndef REF_PLL_CFG_SVH
`define REF_PLL_CFG_SVH

// Byte offsets in the configuration memory
`define OFS_DRIVE        8'h06
`define OFS_LOAD_CAP     8'h07
`define OFS_PRE_BASE     8'h08
`define OFS_FB_BASE      8'h0c
`define OFS_REF_CTRL     8'h34
`define OFS_POST_BASE    8'h40
`define OFS_SS0_BASE     8'h60
`define OFS_SS1_BASE     8'h68
`define OFS_SS_TSSC      8'h00
`define OFS_SS_OFFSET    8'h01

// Field positions
`define REF_PRIM_BIT     0
`define REF_SWITCH_LSB   6
`define FB_A_LSB         4
`define POST_MODE_LSB    2
`define POST_SRC_LSB     4

// Reset values
`define RST_DRIVE        2'h3
`define RST_LOAD_CAP     8'h00
`define RST_PRE          8'h01
`define RST_FB_N         12'h000
`define RST_POST_MODE    2'h1

// Load capacitance base 3.5 pF in 0.125 pF steps
`define CAP_BASE_STEPS   9'h01c
// Fixed modifiers of the divide equations
`define POST_Q_ADD       11'h002
`define FRAC_STEPS       20'h00040
// Frequency control mode in which the select pin is ignored
`define FREQ_CTRL_NO_PIN_SEL 2'h2

`endif

// file: core/ref_pll_pkg.sv
// Types of the reference select and divider block
package ref_pll_pkg;

  localparam int NUM_PLL  = 3;
  localparam int NUM_BANK = 5;

  typedef enum logic [1:0] {
    POST_OFF,
    POST_DIV1,
    POST_DIV2,
    POST_DIVQ
  } post_mode_e;

  typedef struct packed {
    logic [7:0]                  cap;
    logic [1:0]                  drv;
    logic                        prim;
    logic [1:0]                  swmode;
    logic [NUM_PLL-1:0][7:0]     d;
    logic [NUM_PLL-1:0][11:0]    n;
    logic [1:0][3:0]             a;
    logic [1:0][3:0]             tssc;
    logic [1:0][5:0]             ssoff;
    logic [NUM_BANK-1:0][9:0]    q;
    logic [NUM_BANK-1:0][1:0]    pmode;
    logic [NUM_BANK-1:0][1:0]    src;
    logic                        ref_prev;
    logic [NUM_PLL-1:0][7:0]     pre_cnt;
    logic [NUM_PLL-1:0]          pfd;
    logic [NUM_BANK-1:0][10:0]   pcnt;
    logic [NUM_BANK-1:0][10:0]   pdiv;
    logic [NUM_BANK-1:0]         bank_out;
    logic                        out1;
    logic [NUM_PLL-1:0][19:0]    mx64;
    logic [7:0]                  rdata;
    logic                        ref_sel;
  } state_s;

endpackage

// file: core/ref_pll_ctrl.sv
// Reference selection, pre-scalers, feedback ratios and output post-dividers
// How it works
// - Select bit 0 makes the crystal input primary, 1 makes the second input primary.
// - Select pin low routes the primary reference, high routes the secondary.
// - The select pin is ignored in frequency control mode 2; the bit still selects.
// - Load capacitance equals 3.5 pF plus code times 0.125 pF.
// - Each PLL pre-scaler divides the selected reference by 1 to 255.
// - Pre-scaler value zero powers down that PLL and all its outputs.
// - PLL0/1 feedback is 2N+A+1, with A code 0000 counting as -1.
// - With spread on (nonzero TSSC) the feedback adds offset over 64.
// - PLL2 feedback is plain N, 1 to 4095, no adjust or fraction.
// - Feedback N of zero lets the VCO slew to minimum frequency.
// - Banks two to six decode mode: off, div 1, div 2, Q divider.
// - Q divider mode divides by Q plus 2, Q up to 1023.
// - Banks two to six add a fixed divide by 2 after the post-divider.
// - The first output has no post-divider in its path.
// - A disabled bank gives no clock but stays powered.
// - Spread on PLL0/1 folds the offset field into the feedback value.
// - The select pin defaults low through a weak pull-down.
`timescale 1ns/1ps
`include "ref_pll_cfg.svh"

module ref_pll_ctrl (
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_we_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        crystal_or_ref_input_i,
  input  wire logic        second_ref_input_i,
  input  wire logic        general_input_five_i,
  input  wire logic [1:0]  manual_freq_control_i,
  input  wire logic [2:0]  vco_tick_i,
  output logic             ref_selected_o,
  output logic             ref_is_second_o,
  output logic [8:0]       load_cap_steps_o,
  output logic [1:0]       crystal_drive_strength_o,
  output logic [1:0]       switchover_mode_o,
  output logic [2:0]       pfd_tick_o,
  output logic [2:0]       pll_power_down_o,
  output logic [2:0]       vco_slew_min_o,
  output logic [59:0]      feedback_x64_o,
  output logic             out_first_o,
  output logic [4:0]       bank_clk_o,
  output logic [4:0]       bank_powered_o
);

  localparam int NP = ref_pll_pkg::NUM_PLL;
  localparam int NB = ref_pll_pkg::NUM_BANK;

  ref_pll_pkg::state_s s_q;
  ref_pll_pkg::state_s s_d;

  // ==========================================================
  // Decoding helpers
  // ==========================================================
  function automatic logic [10:0] post_div(input logic [1:0] mode, input logic [9:0] q);
    logic [10:0] r;
    r = 11'h001;
    case (ref_pll_pkg::post_mode_e'(mode))
      ref_pll_pkg::POST_OFF:  r = 11'h001;
      ref_pll_pkg::POST_DIV1: r = 11'h001;
      ref_pll_pkg::POST_DIV2: r = 11'h002;
      ref_pll_pkg::POST_DIVQ: r = {1'b0, q} + `POST_Q_ADD;
      default:                r = 11'h001;
    endcase
    return r;
  endfunction

  function automatic logic [1:0] pll_of(input logic [1:0] src);
    return (src == 2'h3) ? 2'h2 : src;
  endfunction

  // ==========================================================
  // Next state
  // ==========================================================
  logic        use_second;
  logic        ref_now;
  logic        ref_rise;
  logic [13:0] m_int;
  logic [1:0]  p;

  always_comb begin
    s_d = s_q;
    m_int = 14'h0000;
    p = 2'h0;

    // Register writes
    if (reg_we_i) begin
      case (reg_addr_i)
        `OFS_DRIVE:    s_d.drv = reg_wdata_i[1:0];
        `OFS_LOAD_CAP: s_d.cap = reg_wdata_i;
        `OFS_REF_CTRL: begin
          s_d.prim = reg_wdata_i[`REF_PRIM_BIT];
          s_d.swmode = reg_wdata_i[`REF_SWITCH_LSB +: 2];
        end
        `OFS_SS0_BASE + `OFS_SS_TSSC:   s_d.tssc[0] = reg_wdata_i[3:0];
        `OFS_SS0_BASE + `OFS_SS_OFFSET: s_d.ssoff[0] = reg_wdata_i[5:0];
        `OFS_SS1_BASE + `OFS_SS_TSSC:   s_d.tssc[1] = reg_wdata_i[3:0];
        `OFS_SS1_BASE + `OFS_SS_OFFSET: s_d.ssoff[1] = reg_wdata_i[5:0];
        default: begin
        end
      endcase
      for (int i = 0; i < NP; i++) begin
        if (reg_addr_i == `OFS_PRE_BASE + 8'(i)) begin
          s_d.d[i] = reg_wdata_i;
        end
        if (reg_addr_i == `OFS_FB_BASE + 8'(2 * i)) begin
          s_d.n[i][7:0] = reg_wdata_i;
        end
        if (reg_addr_i == `OFS_FB_BASE + 8'(2 * i + 1)) begin
          s_d.n[i][11:8] = reg_wdata_i[3:0];
          if (i < 2) begin
            s_d.a[i[0]] = reg_wdata_i[`FB_A_LSB +: 4];
          end
        end
      end
      for (int b = 0; b < NB; b++) begin
        if (reg_addr_i == `OFS_POST_BASE + 8'(2 * b)) begin
          s_d.q[b][7:0] = reg_wdata_i;
        end
        if (reg_addr_i == `OFS_POST_BASE + 8'(2 * b + 1)) begin
          s_d.q[b][9:8] = reg_wdata_i[1:0];
          s_d.pmode[b] = reg_wdata_i[`POST_MODE_LSB +: 2];
          s_d.src[b] = reg_wdata_i[`POST_SRC_LSB +: 2];
        end
      end
    end

    // Register reads, one cycle after the address
    s_d.rdata = 8'h00;
    case (reg_addr_i)
      `OFS_DRIVE:    s_d.rdata = {6'h00, s_q.drv};
      `OFS_LOAD_CAP: s_d.rdata = s_q.cap;
      `OFS_REF_CTRL: s_d.rdata = {s_q.swmode, 4'h0, s_q.ref_sel, s_q.prim};
      `OFS_SS0_BASE + `OFS_SS_TSSC:   s_d.rdata = {4'h0, s_q.tssc[0]};
      `OFS_SS0_BASE + `OFS_SS_OFFSET: s_d.rdata = {2'h0, s_q.ssoff[0]};
      `OFS_SS1_BASE + `OFS_SS_TSSC:   s_d.rdata = {4'h0, s_q.tssc[1]};
      `OFS_SS1_BASE + `OFS_SS_OFFSET: s_d.rdata = {2'h0, s_q.ssoff[1]};
      default: begin
      end
    endcase
    for (int i = 0; i < NP; i++) begin
      if (reg_addr_i == `OFS_PRE_BASE + 8'(i)) begin
        s_d.rdata = s_q.d[i];
      end
      if (reg_addr_i == `OFS_FB_BASE + 8'(2 * i)) begin
        s_d.rdata = s_q.n[i][7:0];
      end
      if (reg_addr_i == `OFS_FB_BASE + 8'(2 * i + 1)) begin
        s_d.rdata = {(i < 2) ? s_q.a[i[0]] : 4'h0, s_q.n[i][11:8]};
      end
    end
    for (int b = 0; b < NB; b++) begin
      if (reg_addr_i == `OFS_POST_BASE + 8'(2 * b)) begin
        s_d.rdata = s_q.q[b][7:0];
      end
      if (reg_addr_i == `OFS_POST_BASE + 8'(2 * b + 1)) begin
        s_d.rdata = {2'h0, s_q.src[b], s_q.pmode[b], s_q.q[b][9:8]};
      end
    end

    // Reference selection; the pin reads low when unconnected thanks to its pull-down
    use_second = general_input_five_i && (manual_freq_control_i != `FREQ_CTRL_NO_PIN_SEL);
    s_d.ref_sel = s_q.prim ^ use_second;
    ref_now = s_q.ref_sel ? second_ref_input_i : crystal_or_ref_input_i;
    s_d.ref_prev = ref_now;
    ref_rise = ref_now && !s_q.ref_prev;

    // Pre-scalers count rising reference edges; a lowered D applies via the >= compare
    for (int i = 0; i < NP; i++) begin
      s_d.pfd[i] = 1'b0;
      if (s_q.d[i] == 8'h00) begin
        s_d.pre_cnt[i] = 8'h00;
      end else if (ref_rise) begin
        if (s_q.pre_cnt[i] + 8'h01 >= s_q.d[i]) begin
          s_d.pre_cnt[i] = 8'h00;
          s_d.pfd[i] = 1'b1;
        end else begin
          s_d.pre_cnt[i] = s_q.pre_cnt[i] + 8'h01;
        end
      end
    end

    // Feedback ratios in 1/64 steps
    for (int i = 0; i < NP; i++) begin
      if (i < 2) begin
        if (s_q.a[i[0]] == 4'h0) begin
          m_int = {1'b0, s_q.n[i], 1'b0};
        end else begin
          m_int = {1'b0, s_q.n[i], 1'b0} + {10'h000, s_q.a[i[0]]} + 14'h0001;
        end
        s_d.mx64[i] = {m_int, 6'h00};
        if (s_q.tssc[i[0]] != 4'h0) begin
          s_d.mx64[i] = {m_int, 6'h00} + {14'h0000, s_q.ssoff[i[0]]};
        end
      end else begin
        s_d.mx64[i] = {2'h0, s_q.n[i], 6'h00};
      end
    end

    // First output follows the PLL0 VCO directly
    s_d.out1 = vco_tick_i[0] && (s_q.d[0] != 8'h00);

    // Post-dividers, each terminal toggles the bank output for the fixed divide by 2
    for (int b = 0; b < NB; b++) begin
      p = pll_of(s_q.src[b]);
      if (s_q.pmode[b] == ref_pll_pkg::POST_OFF || s_q.d[p] == 8'h00) begin
        s_d.pcnt[b] = 11'h000;
        s_d.bank_out[b] = 1'b0;
        s_d.pdiv[b] = post_div(s_q.pmode[b], s_q.q[b]);
      end else if (vco_tick_i[p]) begin
        if (s_q.pcnt[b] + 11'h001 >= s_q.pdiv[b]) begin
          s_d.pcnt[b] = 11'h000;
          s_d.bank_out[b] = !s_q.bank_out[b];
          s_d.pdiv[b] = post_div(s_q.pmode[b], s_q.q[b]);
        end else begin
          s_d.pcnt[b] = s_q.pcnt[b] + 11'h001;
        end
      end
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0;
      s_q.drv <= `RST_DRIVE;
      s_q.cap <= `RST_LOAD_CAP;
      s_q.d <= {NP{`RST_PRE}};
      s_q.n <= {NP{`RST_FB_N}};
      s_q.pmode <= {NB{`RST_POST_MODE}};
      s_q.pdiv <= {NB{11'h001}};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  always_comb begin
    reg_rdata_o = s_q.rdata;
    ref_selected_o = s_q.ref_sel ? second_ref_input_i : crystal_or_ref_input_i;
    ref_is_second_o = s_q.ref_sel;
    load_cap_steps_o = `CAP_BASE_STEPS + {1'b0, s_q.cap};
    crystal_drive_strength_o = s_q.drv;
    switchover_mode_o = s_q.swmode;
    pfd_tick_o = s_q.pfd;
    out_first_o = s_q.out1;
    bank_clk_o = s_q.bank_out;
    for (int i = 0; i < NP; i++) begin
      pll_power_down_o[i] = (s_q.d[i] == 8'h00);
      vco_slew_min_o[i] = (s_q.n[i] == 12'h000);
      feedback_x64_o[20*i +: 20] = s_q.mx64[i];
    end
    for (int b = 0; b < NB; b++) begin
      bank_powered_o[b] = (s_q.d[pll_of(s_q.src[b])] != 8'h00);
    end
  end

endmodule

// file: tb/ref_pll_ctrl_props.sv
// Port checks of the reference select and divider block
`timescale 1ns/1ps
module ref_pll_ctrl_props (
  input wire logic        clk_sys_i,
  input wire logic        arst_n_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_we_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        crystal_or_ref_input_i,
  input wire logic        second_ref_input_i,
  input wire logic        general_input_five_i,
  input wire logic [1:0]  manual_freq_control_i,
  input wire logic [2:0]  vco_tick_i,
  input wire logic        ref_selected_o,
  input wire logic        ref_is_second_o,
  input wire logic [8:0]  load_cap_steps_o,
  input wire logic [2:0]  pfd_tick_o,
  input wire logic [2:0]  pll_power_down_o,
  input wire logic [2:0]  vco_slew_min_o,
  input wire logic [59:0] feedback_x64_o,
  input wire logic        out_first_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // ==========================================
  // Select path sequences
  sequence s_prim_wr;
    reg_we_i && reg_addr_i == 8'h34 ##1 !general_input_five_i && !reg_we_i;
  endsequence
  sequence s_hold2;
    manual_freq_control_i == 2'h2 && !reg_we_i ##1 manual_freq_control_i == 2'h2;
  endsequence
  sequence s_pin_flip;
    manual_freq_control_i != 2'h2 && !reg_we_i ##1 manual_freq_control_i != 2'h2 && $changed(general_input_five_i);
  endsequence
  property p_prim;
    s_prim_wr |=> ref_is_second_o == $past(reg_wdata_i[0], 2);
  endproperty
  property p_mode2;
    s_hold2 |=> $stable(ref_is_second_o);
  endproperty
  property p_pin;
    s_pin_flip |=> $changed(ref_is_second_o);
  endproperty
  property p_mux;
    ref_selected_o == (ref_is_second_o ? second_ref_input_i : crystal_or_ref_input_i);
  endproperty
  property p_cap;
    reg_we_i && reg_addr_i == 8'h07 |=> load_cap_steps_o == 9'h01c + $past(reg_wdata_i);
  endproperty
  property p_unmapped;
    reg_addr_i == 8'hff |=> reg_rdata_o == 8'h00;
  endproperty
  // Both cycles must see the PLL down so a pulse launched before the write is excused
  property p_down;
    pll_power_down_o[0] && $past(pll_power_down_o[0]) |-> !pfd_tick_o[0] && !out_first_o;
  endproperty
  property p_first;
    !pll_power_down_o[0] && !$past(pll_power_down_o[0]) |-> out_first_o == $past(vco_tick_i[0]);
  endproperty
  property p_slew;
    vco_slew_min_o[2] && $past(vco_slew_min_o[2]) |-> feedback_x64_o[59:40] == 20'h00000;
  endproperty
  property p_whole;
    feedback_x64_o[45:40] == 6'h00;
  endproperty
  a_prim: assert property (p_prim) else $error("select bit not followed");
  a_mode2: assert property (p_mode2) else $error("select pin acted in mode 2");
  a_pin: assert property (p_pin) else $error("select pin ignored");
  a_mux: assert property (p_mux) else $error("wrong reference routed");
  a_cap: assert property (p_cap) else $error("load cap steps wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_down: assert property (p_down) else $error("activity on powered down PLL");
  a_first: assert property (p_first) else $error("first output not undivided");
  a_slew: assert property (p_slew) else $error("zero N gave nonzero ratio");
  a_whole: assert property (p_whole) else $error("third PLL ratio has fraction");
endmodule

// file: tb/tb.sv
// Self-checking bench of the reference select and divider block
`timescale 1ns/1ps
module tb;
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_we_i = 1'b0;
  logic        crystal_or_ref_input_i = 1'b0;
  logic        second_ref_input_i = 1'b0;
  logic        general_input_five_i = 1'b0;
  logic [1:0]  manual_freq_control_i = 2'h0;
  logic [2:0]  vco_tick_i = 3'h0;
  logic [7:0]  reg_rdata_o;
  logic        ref_selected_o, ref_is_second_o, out_first_o;
  logic [8:0]  load_cap_steps_o;
  logic [1:0]  crystal_drive_strength_o, switchover_mode_o;
  logic [2:0]  pfd_tick_o, pll_power_down_o, vco_slew_min_o;
  logic [59:0] feedback_x64_o;
  logic [4:0]  bank_clk_o, bank_powered_o;
  int          failures = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          n, t;

  always #50 clk_sys_i = ~clk_sys_i;

  ref_pll_ctrl dut (.clk_sys_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_rdata_o,
    .crystal_or_ref_input_i, .second_ref_input_i, .general_input_five_i, .manual_freq_control_i,
    .vco_tick_i, .ref_selected_o, .ref_is_second_o, .load_cap_steps_o, .crystal_drive_strength_o,
    .switchover_mode_o, .pfd_tick_o, .pll_power_down_o, .vco_slew_min_o, .feedback_x64_o,
    .out_first_o, .bank_clk_o, .bank_powered_o);

  task automatic check(input logic [59:0] seen, input logic [59:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_we_i = 1'b1;
    @(negedge clk_sys_i);
    reg_we_i = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    @(negedge clk_sys_i);
    check(reg_rdata_o, exp);
  endtask
  // Toggles the reference k times and ticks every VCO k times, then lets the pipeline drain
  task automatic run(input int k, output int pf, output int tg);
    logic last;
    pf = 0;
    tg = 0;
    last = bank_clk_o[0];
    for (int i = 0; i < k + 3; i++) begin
      @(negedge clk_sys_i);
      pf += int'(pfd_tick_o[0] === 1'b1);
      tg += int'(bank_clk_o[0] !== last);
      last = bank_clk_o[0];
      crystal_or_ref_input_i = (i < k) ? ~crystal_or_ref_input_i : 1'b0;
      vco_tick_i = (i < k) ? 3'h7 : 3'h0;
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      print_verdict();
    end
  end

  // ==========================================
  // Test sequence
  initial begin
    repeat (20) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    check(load_cap_steps_o, 9'h01c);
    check(crystal_drive_strength_o, 2'h3);
    check(vco_slew_min_o, 3'h7);
    rdc(8'h07, 8'h00);
    wr(8'h07, 8'h10);
    check(load_cap_steps_o, 9'h02c);
    rdc(8'h07, 8'h10);
    wr(8'hff, 8'h5a);
    rdc(8'hff, 8'h00);
    $display("register test done");
    crystal_or_ref_input_i = 1'b1;
    for (int v = 0; v < 8; v++) begin
      wr(8'h34, {7'h00, v[0]});
      // A quiet edge after the write lets the pin change be seen on its own
      @(negedge clk_sys_i);
      general_input_five_i = v[1];
      manual_freq_control_i = v[2] ? 2'h2 : 2'h1;
      repeat (2) @(negedge clk_sys_i);
      check(ref_is_second_o, v[0] ^ (v[1] & !v[2]));
      check(ref_selected_o, !(v[0] ^ (v[1] & !v[2])));
    end
    wr(8'h34, 8'h40);
    general_input_five_i = 1'b0;
    crystal_or_ref_input_i = 1'b0;
    check(switchover_mode_o, 2'h1);
    rdc(8'h34, 8'h40);
    $display("select test done");
    wr(8'h0c, 8'h20);
    wr(8'h0d, 8'h30);
    @(negedge clk_sys_i);
    check(feedback_x64_o[19:0], 20'h01100);
    wr(8'h0d, 8'h00);
    @(negedge clk_sys_i);
    check(feedback_x64_o[19:0], 20'h01000);
    wr(8'h60, 8'h05);
    wr(8'h61, 8'h30);
    @(negedge clk_sys_i);
    check(feedback_x64_o[19:0], 20'h01030);
    wr(8'h10, 8'hff);
    wr(8'h11, 8'h0f);
    @(negedge clk_sys_i);
    check(feedback_x64_o[59:40], 20'h3ffc0);
    check(vco_slew_min_o, 3'h2);
    $display("feedback test done");
    wr(8'h08, 8'h00);
    check(pll_power_down_o[0], 1'b1);
    check(bank_powered_o[0], 1'b0);
    run(24, n, t);
    check(n + t, 0);
    wr(8'h08, 8'h03);
    run(24, n, t);
    check(n, 4);
    wr(8'h08, 8'h01);
    run(24, n, t);
    check(n, 12);
    $display("prescaler test done");
    wr(8'h40, 8'h01);
    for (int m = 1; m < 5; m++) begin
      wr(8'h41, {4'h0, m[1:0], 2'h0});
      run(6, n, t);
      run(12, n, t);
      check(t, m == 4 ? 0 : 12 / m);
    end
    check(bank_clk_o[0], 1'b0);
    check(bank_powered_o[0], 1'b1);
    $display("post divider test done");
    print_verdict();
  end
endmodule

bind ref_pll_ctrl ref_pll_ctrl_props u_props (.clk_sys_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
  .reg_rdata_o, .crystal_or_ref_input_i, .second_ref_input_i, .general_input_five_i, .manual_freq_control_i,
  .vco_tick_i, .ref_selected_o, .ref_is_second_o, .load_cap_steps_o, .pfd_tick_o, .pll_power_down_o,
  .vco_slew_min_o, .feedback_x64_o, .out_first_o);
